// ==== bsd_pkg.sv ====
`default_nettype none
package bsd_pkg;

  // Clock rate and link timing.
  localparam int CLK_HZ = 25_000_000;
  localparam int FS_MIN_HZ = 32_000;
  localparam int FS_MAX_HZ = 192_000;
  localparam int SUBFRAMES_PER_FRAME = 2;
  localparam int PRE_JITTER_CYC = 2;
  // Shortest and longest legal gap between subframe sync preambles.
  localparam int PRE_MIN_CYC =
    CLK_HZ / (SUBFRAMES_PER_FRAME * FS_MAX_HZ) - PRE_JITTER_CYC;
  localparam int PRE_MAX_CYC =
    (CLK_HZ + SUBFRAMES_PER_FRAME * FS_MIN_HZ - 1) /
    (SUBFRAMES_PER_FRAME * FS_MIN_HZ) + PRE_JITTER_CYC;
  localparam int LOCK_TIME_MS = 20;
  localparam int LOCK_TIME_CYC = (CLK_HZ / 1000) * LOCK_TIME_MS;
  localparam int LOCK_GOOD_INTERVALS = 8;
  localparam int HOLD_FRAMES = 4096;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BURST = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

  // Field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_UOE_BIT = 2;
  localparam int ST_NON_PCM_FLAG_BIT = 0;
  localparam int ST_SCD_BIT = 1;
  localparam int ST_AUTO_BIT = 2;
  localparam int ST_UNLOCK_BIT = 3;
  localparam int IRQ_NON_PCM_FLAG_BIT = 0;
  localparam int IRQ_SCD_BIT = 1;
  localparam int IRQ_UNLOCK_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // Sync words of the recognised bitstreams.
  localparam logic [15:0] NON_PCM_FLAG_SYNC_A = 16'hf872;
  localparam logic [15:0] NON_PCM_FLAG_SYNC_B = 16'h4e1f;
  localparam logic [15:0] SCD14_SYNC_A = 16'h1fff;
  localparam logic [15:0] SCD14_SYNC_B = 16'he800;
  localparam logic [15:0] SCD16_SYNC_A = 16'h7ffe;
  localparam logic [15:0] SCD16_SYNC_B = 16'h8001;
  localparam int SYNC_WORDS = 6;

  typedef enum logic [1:0] {
    MODE_PLL = 2'h0,
    MODE_XTAL = 2'h1,
    MODE_AUTO = 2'h2,
    MODE_MONITOR = 2'h3
  } clock_mode_e;

  localparam clock_mode_e MODE_RESET = MODE_AUTO;

  typedef struct packed {
    logic user_bit_out_enable;
    clock_mode_e clock_mode_select;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{user_bit_out_enable: 1'b0,
                                   clock_mode_select: MODE_RESET};

  typedef struct packed {
    logic [15:0] burst_length_word;
    logic [15:0] burst_info_word;
  } burst_s;

  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_INFO = 3'b010,
    CAP_LEN = 3'b100
  } cap_state_e;

endpackage
`default_nettype wire

// ==== sync_hold_flag.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync_hold_flag #(
  parameter int HOLD = 4096,
  parameter int CW = 13
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_detect,
  input wire logic i_frame_strobe,
  output logic o_flag,
  output logic [CW-1:0] o_frames
);

  // The flag rises on a detection and falls after HOLD quiet frames.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_flag <= 1'b0;
      o_frames <= '0;
    end
    else if (i_detect)
    begin
      o_flag <= 1'b1;
      o_frames <= '0;
    end
    else if (o_flag && i_frame_strobe)
    begin
      if (o_frames == CW'(HOLD - 1))
      begin
        o_flag <= 1'b0;
        o_frames <= '0;
      end
      else
      begin
        o_frames <= o_frames + CW'(1);
      end
    end
  end

endmodule // sync_hold_flag
`default_nettype wire

// ==== bitstream_detect_clock_mode.sv ====
`timescale 1ns/1ps
`default_nettype none
module bitstream_detect_clock_mode #(
  parameter int HOLD_FRAMES = bsd_pkg::HOLD_FRAMES,
  parameter int LOCK_TIME_CYC = bsd_pkg::LOCK_TIME_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_power_down_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rx_word_valid,
  input wire logic [15:0] i_rx_word,
  input wire logic i_rx_frame_strobe,
  input wire logic i_rx_preamble,
  input wire logic i_rx_audio_bit,
  input wire logic i_rx_user_bit,
  input wire logic i_aux_audio_in,
  input wire logic i_pll_clk_level,
  input wire logic i_xtal_clk_level,
  output logic o_serial_audio_out,
  output logic o_master_clock_out,
  output logic o_user_bit_pin,
  output logic o_pll_enable,
  output logic o_clk_src_xtal,
  output logic o_irq
);

  localparam int CW = $clog2(HOLD_FRAMES) + 1;

  logic rst_n;
  logic [15:0] word_q [bsd_pkg::SYNC_WORDS];
  logic non_pcm_flag_hit;
  logic scd_hit;
  logic scd16_seen;
  logic [1:0] hit;
  logic [1:0] flag;
  logic [CW-1:0] frames [2];
  bsd_pkg::cap_state_e cap_q;
  bsd_pkg::burst_s burst_q;
  bsd_pkg::ctrl_s ctrl_q;
  logic [15:0] gap_q;
  logic [15:0] prev_gap_q;
  logic [15:0] gap_now;
  logic [15:0] gap_diff;
  logic gap_bad;
  logic gap_timeout;
  logic [3:0] good_run_q;
  logic unlock_q;
  logic use_xtal;
  logic [bsd_pkg::IRQ_W-1:0] irq_status_q;
  logic [bsd_pkg::IRQ_W-1:0] irq_enable_q;
  logic [bsd_pkg::IRQ_W-1:0] irq_event;
  logic setup_rd;
  logic access_wr;
  logic mapped;
  logic [31:0] rd_mux;
  logic live_q;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!live_q);

  // Power-down acts as a second reset for every flip-flop.
  assign rst_n = i_rst_b & i_power_down_n;

  // Checks other than the power-down one stay off until one edge after reset, when the pins are loaded.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      live_q <= 1'b0;
    end
    else
    begin
      live_q <= 1'b1;
    end
  end

  // Keep the last six received words for pattern matching.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < bsd_pkg::SYNC_WORDS; i++)
      begin
        word_q[i] <= 16'h0000;
      end
    end
    else if (i_rx_word_valid)
    begin
      word_q[0] <= i_rx_word;
      for (int i = 1; i < bsd_pkg::SYNC_WORDS; i++)
      begin
        word_q[i] <= word_q[i-1];
      end
    end
  end

  // Match the newest word against the sync patterns as it arrives.
  assign non_pcm_flag_hit = i_rx_word_valid && (i_rx_word == bsd_pkg::NON_PCM_FLAG_SYNC_B) &&
                    (word_q[0] == bsd_pkg::NON_PCM_FLAG_SYNC_A) &&
                    (word_q[1] == 16'h0000) && (word_q[2] == 16'h0000) &&
                    (word_q[3] == 16'h0000) && (word_q[4] == 16'h0000);
  assign scd_hit = i_rx_word_valid && (i_rx_word == bsd_pkg::SCD14_SYNC_B) &&
                   (word_q[0] == bsd_pkg::SCD14_SYNC_A);
  assign scd16_seen = i_rx_word_valid &&
                      (i_rx_word == bsd_pkg::SCD16_SYNC_B) &&
                      (word_q[0] == bsd_pkg::SCD16_SYNC_A);
  assign hit = {scd_hit, non_pcm_flag_hit};

  // One hold timer per detected stream type.
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_hold
      sync_hold_flag #(
        .HOLD(HOLD_FRAMES),
        .CW(CW)
      ) u_hold (
        .i_clk(i_clk),
        .i_rst_b(rst_n),
        .i_detect(hit[g]),
        .i_frame_strobe(i_rx_frame_strobe),
        .o_flag(flag[g]),
        .o_frames(frames[g])
      );
    end
  endgenerate

  // Capture the two burst preamble words that trail a non-PCM sync.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_q <= bsd_pkg::CAP_IDLE;
      burst_q <= '0;
    end
    else
    begin
      case (cap_q)
        bsd_pkg::CAP_IDLE:
        begin
          if (non_pcm_flag_hit)
          begin
            cap_q <= bsd_pkg::CAP_INFO;
          end
        end
        bsd_pkg::CAP_INFO:
        begin
          if (i_rx_word_valid)
          begin
            burst_q.burst_info_word <= i_rx_word;
            cap_q <= bsd_pkg::CAP_LEN;
          end
        end
        bsd_pkg::CAP_LEN:
        begin
          if (i_rx_word_valid)
          begin
            burst_q.burst_length_word <= i_rx_word;
            cap_q <= bsd_pkg::CAP_IDLE;
          end
        end
        default:
        begin
          cap_q <= bsd_pkg::CAP_IDLE;
        end
      endcase
    end
  end

  // Measure the gap between preambles and judge it against the lock range.
  assign gap_now = gap_q + 16'h0001;
  assign gap_diff = (gap_now > prev_gap_q) ? gap_now - prev_gap_q :
                    prev_gap_q - gap_now;
  assign gap_timeout = gap_q == 16'(bsd_pkg::PRE_MAX_CYC);
  assign gap_bad = gap_timeout ||
                   (i_rx_preamble &&
                    ((gap_now < 16'(bsd_pkg::PRE_MIN_CYC)) ||
                     (gap_now > 16'(bsd_pkg::PRE_MAX_CYC)) ||
                     (gap_diff > 16'(bsd_pkg::PRE_JITTER_CYC))));

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap_q <= 16'h0000;
      prev_gap_q <= 16'h0000;
    end
    else if (i_rx_preamble)
    begin
      gap_q <= 16'h0000;
      prev_gap_q <= gap_now;
    end
    else if (!gap_timeout)
    begin
      gap_q <= gap_now;
    end
  end

  // Lock returns after a run of good gaps; any bad gap drops it at once.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      good_run_q <= 4'h0;
      unlock_q <= 1'b1;
    end
    else if (gap_bad)
    begin
      good_run_q <= 4'h0;
      unlock_q <= 1'b1;
    end
    else if (i_rx_preamble && unlock_q)
    begin
      if (good_run_q == 4'(bsd_pkg::LOCK_GOOD_INTERVALS - 1))
      begin
        unlock_q <= 1'b0;
        good_run_q <= 4'h0;
      end
      else
      begin
        good_run_q <= good_run_q + 4'h1;
      end
    end
  end

  // Pick the clock and data source from the mode and lock state.
  always_comb
  begin
    case (ctrl_q.clock_mode_select)
      bsd_pkg::MODE_PLL: use_xtal = 1'b0;
      bsd_pkg::MODE_XTAL: use_xtal = 1'b1;
      bsd_pkg::MODE_AUTO: use_xtal = unlock_q;
      bsd_pkg::MODE_MONITOR: use_xtal = 1'b1;
      default: use_xtal = 1'b1;
    endcase
  end

  // Registered audio, clock and source pins follow the chosen source; PLL enable follows the mode, the user-bit pin its enable.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_serial_audio_out <= 1'b0;
      o_master_clock_out <= 1'b0;
      o_user_bit_pin <= 1'b0;
      o_pll_enable <= 1'b0;
      o_clk_src_xtal <= 1'b0;
    end
    else
    begin
      o_serial_audio_out <= use_xtal ? i_aux_audio_in : i_rx_audio_bit;
      o_master_clock_out <= use_xtal ? i_xtal_clk_level : i_pll_clk_level;
      o_user_bit_pin <= ctrl_q.user_bit_out_enable & i_rx_user_bit;
      o_pll_enable <= ctrl_q.clock_mode_select != bsd_pkg::MODE_XTAL;
      o_clk_src_xtal <= use_xtal;
    end
  end

  // APB decode; the slave never inserts wait states.
  assign setup_rd = i_psel && !i_penable && !i_pwrite;
  assign access_wr = i_psel && i_penable && i_pwrite;
  assign mapped = (i_paddr == bsd_pkg::OFS_CTRL) ||
                  (i_paddr == bsd_pkg::OFS_STATUS) ||
                  (i_paddr == bsd_pkg::OFS_BURST) ||
                  (i_paddr == bsd_pkg::OFS_IRQ_STATUS) ||
                  (i_paddr == bsd_pkg::OFS_IRQ_CLEAR) ||
                  (i_paddr == bsd_pkg::OFS_IRQ_ENABLE);
  assign o_pready = rst_n;
  assign o_pslverr = rst_n && i_psel && i_penable && !mapped;

  // Read data is prepared in the setup cycle so it comes from a flop.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      bsd_pkg::OFS_CTRL: rd_mux[2:0] = ctrl_q;
      bsd_pkg::OFS_STATUS:
      begin
        rd_mux[bsd_pkg::ST_NON_PCM_FLAG_BIT] = flag[0];
        rd_mux[bsd_pkg::ST_SCD_BIT] = flag[1];
        rd_mux[bsd_pkg::ST_AUTO_BIT] = flag[0] | flag[1];
        rd_mux[bsd_pkg::ST_UNLOCK_BIT] = unlock_q;
      end
      bsd_pkg::OFS_BURST: rd_mux = burst_q;
      bsd_pkg::OFS_IRQ_STATUS: rd_mux[bsd_pkg::IRQ_W-1:0] = irq_status_q;
      bsd_pkg::OFS_IRQ_ENABLE: rd_mux[bsd_pkg::IRQ_W-1:0] = irq_enable_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_prdata <= 32'h0000_0000;
    end
    else if (setup_rd)
    begin
      o_prdata <= rd_mux;
    end
  end

  // Control and interrupt enable writes; power-down restores defaults.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= bsd_pkg::CTRL_RESET;
      irq_enable_q <= bsd_pkg::IRQ_RESET;
    end
    else if (access_wr && (i_paddr == bsd_pkg::OFS_CTRL))
    begin
      ctrl_q <= i_pwdata[2:0];
    end
    else if (access_wr && (i_paddr == bsd_pkg::OFS_IRQ_ENABLE))
    begin
      irq_enable_q <= i_pwdata[bsd_pkg::IRQ_W-1:0];
    end
  end

  // Sticky event bits; a new event beats a clear in the same cycle.
  assign irq_event = {gap_bad & !unlock_q, scd_hit, non_pcm_flag_hit};

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status_q <= bsd_pkg::IRQ_RESET;
    end
    else if (access_wr && (i_paddr == bsd_pkg::OFS_IRQ_CLEAR))
    begin
      irq_status_q <= (irq_status_q & ~i_pwdata[bsd_pkg::IRQ_W-1:0]) |
                      irq_event;
    end
    else
    begin
      irq_status_q <= irq_status_q | irq_event;
    end
  end

  assign o_irq = |(irq_status_q & irq_enable_q);

  // Checks on the detection, lock and output behaviour.
  sequence s_status_read;
    setup_rd && (i_paddr == bsd_pkg::OFS_STATUS) ##1 i_penable;
  endsequence

  a_non_pcm_flag_flag_set: assert property (non_pcm_flag_hit |=> flag[0] && frames[0] == '0)
    else $error("non-PCM flag not set on sync");
  a_non_pcm_flag_hold_clear: assert property ($fell(flag[0]) |->
    $past(frames[0]) == CW'(HOLD_FRAMES - 1) && $past(i_rx_frame_strobe))
    else $error("non-PCM flag fell early");
  a_burst_info_take: assert property (cap_q == bsd_pkg::CAP_INFO &&
    i_rx_word_valid |=> burst_q.burst_info_word == $past(i_rx_word) &&
    cap_q == bsd_pkg::CAP_LEN)
    else $error("burst info word not captured");
  a_scd_hold_clear: assert property ($fell(flag[1]) |->
    $past(frames[1]) == CW'(HOLD_FRAMES - 1) && !$past(scd_hit))
    else $error("surround flag fell early");
  a_auto_bit_read: assert property (s_status_read |->
    o_prdata[bsd_pkg::ST_AUTO_BIT] ==
    (o_prdata[bsd_pkg::ST_NON_PCM_FLAG_BIT] | o_prdata[bsd_pkg::ST_SCD_BIT]))
    else $error("auto bit is not the OR of the flags");
  a_scd16_ignored: assert property (scd16_seen && !flag[1] |=> !flag[1])
    else $error("16-bit sync set surround flag");
  a_unlock_on_gap: assert property (gap_bad |=> unlock_q ##1 unlock_q)
    else $error("bad preamble gap kept lock");
  a_lock_after_run: assert property ($fell(unlock_q) |->
    $past(good_run_q) == 4'(bsd_pkg::LOCK_GOOD_INTERVALS - 1))
    else $error("lock regained without a full good run");
  a_mode_xtal_src: assert property (ctrl_q.clock_mode_select ==
    bsd_pkg::MODE_XTAL |=> !o_pll_enable && o_clk_src_xtal)
    else $error("crystal mode left PLL running");
  a_auto_fallback: assert property (ctrl_q.clock_mode_select ==
    bsd_pkg::MODE_AUTO |=> o_clk_src_xtal == $past(unlock_q))
    else $error("auto mode source wrong");
  a_monitor_mode: assert property (ctrl_q.clock_mode_select ==
    bsd_pkg::MODE_MONITOR |=> o_pll_enable && o_clk_src_xtal)
    else $error("monitor mode source wrong");
  a_serial_audio_out_follows: assert property (##1 o_serial_audio_out ==
    ($past(use_xtal) ? $past(i_aux_audio_in) : $past(i_rx_audio_bit)))
    else $error("serial audio from wrong source");
  a_user_pin_low: assert property (!ctrl_q.user_bit_out_enable |=>
    !o_user_bit_pin)
    else $error("user-bit pin high while disabled");
  a_pdn_outputs_low: assert property (@(posedge i_clk) disable iff (1'b0)
    !i_power_down_n |-> !o_irq && !o_pready && !o_serial_audio_out &&
    !o_master_clock_out && ctrl_q == bsd_pkg::CTRL_RESET)
    else $error("outputs not low in power-down");

endmodule // bitstream_detect_clock_mode
`default_nettype wire

// ==== tx_stream_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Stands in for the biphase transmitter and front end feeding the receiver.
module tx_stream_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  output logic o_valid,
  output logic [15:0] o_word,
  output logic o_frame,
  output logic o_pre,
  output logic o_audio,
  output logic o_user
);
  int gap = 0;
  int cnt = 0;
  logic odd = 1'b0;
  logic [4:0] lfsr = 5'h01;
  initial
  begin
    o_valid = 1'b0;
    o_word = 16'h0;
  end
  // Preambles every gap cycles, a frame on every second one; still at gap 0.
  always @(posedge i_clk)
  begin
    if (!i_rst_b || gap == 0)
    begin
      cnt <= 0;
      o_pre <= 1'b0;
      o_frame <= 1'b0;
    end
    else if (cnt >= gap - 1)
    begin
      cnt <= 0;
      o_pre <= 1'b1;
      odd <= ~odd;
      o_frame <= odd;
    end
    else
    begin
      cnt <= cnt + 1;
      o_pre <= 1'b0;
      o_frame <= 1'b0;
    end
  end
  // Received data and user bits take a new LFSR bit every cycle.
  always @(posedge i_clk)
  begin
    lfsr <= {lfsr[3:0], lfsr[4] ^ lfsr[2]};
    o_audio <= lfsr[0];
    o_user <= lfsr[3];
  end
  // Changes the preamble spacing from the next edge on.
  task set_gap(input int g);
    gap <= g;
  endtask
  // One received word; the line shows the inverse once it is released.
  task send(input logic [15:0] w);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_word <= w;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_word <= ~w;
  endtask
endmodule // tx_stream_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int HOLD = 8;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic pdn_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic aux = 1'b0;
  logic pll_l = 1'b0;
  logic xtal_l = 1'b0;
  logic rx_valid, rx_frame, rx_pre, rx_audio, rx_user;
  logic [15:0] rx_word;
  logic [31:0] prdata;
  logic pready, pslverr, sdo, mclk, ubit, pll_en, xtal_src, irq;
  logic [31:0] rd;
  logic err;
  logic [15:0] info, len;
  logic [1:0] modes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  int gaps [3] = '{390, 66, 100};
  int errors = 0;
  int n_tests = 0;

  bitstream_detect_clock_mode #(.HOLD_FRAMES(HOLD)) u_bitstream_detect_clock_mode (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_power_down_n(pdn_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr),
    .i_rx_word_valid(rx_valid), .i_rx_word(rx_word),
    .i_rx_frame_strobe(rx_frame), .i_rx_preamble(rx_pre),
    .i_rx_audio_bit(rx_audio), .i_rx_user_bit(rx_user),
    .i_aux_audio_in(aux), .i_pll_clk_level(pll_l),
    .i_xtal_clk_level(xtal_l), .o_serial_audio_out(sdo),
    .o_master_clock_out(mclk), .o_user_bit_pin(ubit),
    .o_pll_enable(pll_en), .o_clk_src_xtal(xtal_src), .o_irq(irq));

  tx_stream_model u_tx (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .o_valid(rx_valid), .o_word(rx_word), .o_frame(rx_frame),
    .o_pre(rx_pre), .o_audio(rx_audio), .o_user(rx_user));

  // Clock of 40 ns.
  always #20 i_clk = ~i_clk;

  // Aux data and the two clock levels vary independently of each other.
  always @(posedge i_clk)
  begin
    {aux, pll_l, xtal_l} <= 3'($urandom);
  end

  task give_verdict;
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      errors++;
      give_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task poll_unlock(input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, bsd_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rd[3] !== v && n < 2000);
    chk(rd[3], v);
  endtask

  task frames(input int k);
    int n;
    n = 0;
    repeat (k)
    begin
      do
      begin
        @(posedge i_clk);
        n++;
      end while (rx_frame !== 1'b1 && n < 5000);
    end
    if (n >= 5000)
    begin
      errors++;
      give_verdict;
    end
  endtask

  // Sends k words from the top of v, starting just after a preamble.
  task words(input logic [127:0] v, input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (rx_pre !== 1'b1 && n < 1000);
    if (n >= 1000)
    begin
      errors++;
      give_verdict;
    end
    for (int i = 0; i < k; i++)
      u_tx.send(v[127 - 16 * i -: 16]);
  endtask

  // A flag stays through HOLD-1 quiet frames and drops on the last.
  task hold(input int b);
    frames(HOLD - 1);
    apb(1'b0, bsd_pkg::OFS_STATUS, 32'h0);
    chk(rd[b], 1'b1);
    frames(1);
    apb(1'b0, bsd_pkg::OFS_STATUS, 32'h0);
    chk(rd[b], 1'b0);
  endtask

  function automatic logic [4:0] path_exp(input logic xt, pe, ue, u, x,
                                          p, a, r);
    return {xt, pe, ue & u, xt ? x : p, xt ? a : r};
  endfunction

  // Checks clock source, PLL enable and the three output paths.
  task paths(input logic xt, input logic pe, input logic ue);
    logic [4:0] e;
    repeat (4)
    begin
      @(posedge i_clk);
      e = path_exp(xt, pe, ue, rx_user, xtal_l, pll_l, aux, rx_audio);
      #1;
      chk({xtal_src, pll_en, ubit, mclk, sdo}, e);
    end
  endtask

  initial
  begin
    void'($urandom(58));
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1;
    chk({pll_en, xtal_src}, 2'b11);
    rdchk(bsd_pkg::OFS_CTRL, 32'h2);
    rdchk(bsd_pkg::OFS_STATUS, 32'h8);
    rdchk(bsd_pkg::OFS_BURST, 32'h0);
    apb(1'b1, bsd_pkg::OFS_STATUS, 32'hf);
    rdchk(bsd_pkg::OFS_STATUS, 32'h8);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    foreach (gaps[i])
    begin
      u_tx.set_gap(gaps[i]);
      poll_unlock(1'b1);
      poll_unlock(1'b0);
    end
    paths(1'b0, 1'b1, 1'b0);
    apb(1'b1, bsd_pkg::OFS_CTRL, 32'h6);
    paths(1'b0, 1'b1, 1'b1);
    words({16'hffff, 48'h0, 16'hf872, 16'h4e1f, 32'h0}, 6);
    words({16'h7ffe, 16'h8001, 96'h0}, 2);
    rdchk(bsd_pkg::OFS_STATUS, 32'h0);
    rdchk(bsd_pkg::OFS_IRQ_STATUS, 32'h4);
    apb(1'b1, bsd_pkg::OFS_IRQ_CLEAR, 32'h7);
    apb(1'b1, bsd_pkg::OFS_IRQ_ENABLE, 32'h7);
    {info, len} = 32'($urandom);
    words({64'h0, 16'hf872, 16'h4e1f, info, len}, 8);
    rdchk(bsd_pkg::OFS_STATUS, 32'h5);
    rdchk(bsd_pkg::OFS_BURST, {len, info});
    chk(irq, 1'b1);
    rdchk(bsd_pkg::OFS_IRQ_STATUS, 32'h1);
    apb(1'b1, bsd_pkg::OFS_IRQ_CLEAR, 32'h7);
    #1;
    chk(irq, 1'b0);
    hold(0);
    apb(1'b1, bsd_pkg::OFS_IRQ_ENABLE, 32'h0);
    words({16'h1fff, 16'he800, 96'h0}, 2);
    rdchk(bsd_pkg::OFS_STATUS, 32'h6);
    chk(irq, 1'b0);
    rdchk(bsd_pkg::OFS_IRQ_STATUS, 32'h2);
    hold(1);
    foreach (modes[i])
    begin
      apb(1'b1, bsd_pkg::OFS_CTRL, {30'h0, modes[i]});
      paths(modes[i][0], modes[i] != 2'h1, 1'b0);
    end
    apb(1'b1, bsd_pkg::OFS_CTRL, 32'h2);
    u_tx.set_gap(40);
    poll_unlock(1'b1);
    paths(1'b1, 1'b1, 1'b0);
    apb(1'b1, bsd_pkg::OFS_CTRL, 32'h0);
    paths(1'b0, 1'b1, 1'b0);
    pdn_n <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({prdata[7:0], pready, sdo, mclk, ubit, pll_en, xtal_src, irq}, 0);
    @(posedge i_clk);
    pdn_n <= 1'b1;
    rdchk(bsd_pkg::OFS_CTRL, 32'h2);
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
